//--- dv/fsl_leds_monitor.sv
// Checker for the status LED block, bound to its ports.
// Assumes word accesses with CTRL at offset 0, bit 0 the variant.
`timescale 1ns/10ps
module fsl_leds_monitor
(
  input wire logic                       hclk,
  input wire logic                       hresetn,
  input wire logic                       hsel,
  input wire logic [31:0]                haddr,
  input wire logic [1:0]                 htrans,
  input wire logic                       hwrite,
  input wire logic [31:0]                hwdata,
  input wire logic                       hready,
  input wire logic                       hreadyout,
  input wire logic                       hresp,
  input wire fsl_pkg::fsl_rt_state_type  rt_state,
  input wire fsl_pkg::fsl_eip_state_type eip_state,
  input wire fsl_pkg::fsl_port_type      port_zero_channel,
  input wire logic [7:0]                 net_addr,
  input wire logic [7:0]                 card_addr,
  input wire fsl_pkg::fsl_led_type       first_port_connector,
  input wire fsl_pkg::fsl_led_type       second_port_connector,
  input wire logic                       port_zero_link_led,
  input wire logic [7:0]                 fieldbus_addr
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic wa_r;
  logic var_r;
  logic src_r;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wa_r  <= 1'b0;
      var_r <= 1'b0;
      src_r <= 1'b0;
    end
    else
    begin
      wa_r <= hsel && hready && htrans[1] && hwrite && haddr[7:0] == 8'h00;
      if (wa_r)
      begin
        var_r <= hwdata[0];
        src_r <= hwdata[1];
      end
    end
  end
  sequence s_st;
    var_r && eip_state.powered && eip_state.ip_assigned && eip_state.net_self_test;
  endsequence
  AST_BUS_OKAY:
    assert property (hreadyout && !hresp) else $error("bus not okay");
  AST_BF_ON:
    assert property (!var_r && (rt_state.no_config || rt_state.low_speed || rt_state.no_link)
      |=> first_port_connector.red) else $error("bus fault not lit");
  AST_SF_ON:
    assert property (!var_r && (rt_state.wdog_timeout || rt_state.sys_error
      || rt_state.diag_pending) |=> second_port_connector.red) else $error("system fault dark");
  AST_NS_OFF:
    assert property (var_r && !(eip_state.powered && eip_state.ip_assigned)
      |=> first_port_connector == '0) else $error("network lamp not dark");
  AST_NS_ALT:
    assert property (s_st |=> first_port_connector.red != first_port_connector.green)
      else $error("self-test not alternating");
  AST_MS_MAJOR:
    assert property (var_r && eip_state.powered && !eip_state.mod_self_test
      && eip_state.major_fault |=> second_port_connector == 2'b10) else $error("major not red");
  AST_LINK_OFF:
    assert property (!port_zero_channel.link_up |=> !port_zero_link_led)
      else $error("link lamp lit without link");
  AST_ADDR:
    assert property (hresetn |=> fieldbus_addr == ($past(src_r) ? $past(card_addr)
      : $past(net_addr))) else $error("address from wrong source");
endmodule
bind fsl_leds fsl_leds_monitor i_mon
(
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp,
  .rt_state, .eip_state, .port_zero_channel, .net_addr, .card_addr, .first_port_connector,
  .second_port_connector, .port_zero_link_led, .fieldbus_addr
);

//--- dv/fsl_partner.sv
// Partner model: link state and frame traffic of the two ports.
// Assumes the bench sets link and traffic levels just after hclk edges.
`timescale 1ns/10ps
module fsl_partner
(
  input  wire logic             hclk,
  input  wire logic             link0,
  input  wire logic             link1,
  input  wire logic             traffic,
  output fsl_pkg::fsl_port_type p0,
  output fsl_pkg::fsl_port_type p1
);
  initial
  begin
    p0 = '0;
    p1 = '0;
  end
  always @(posedge hclk)
  begin
    p0 <= '{link_up: link0, activity: link0 & traffic};
    p1 <= '{link_up: link1, activity: link1 & traffic};
  end
endmodule

//--- dv/tb_fsl_leds.sv
// Testbench for the status LED block: bus tasks, LED windows, interrupt path.
// Assumes the partner model drives both port channels; half period set to 8 cycles.
`timescale 1ns/10ps
`include "fsl_cfg.svh"
module tb_fsl_leds;
  logic                       hclk = 1'b0;
  logic                       hresetn = 1'b0;
  logic                       hsel = 1'b0;
  logic [31:0]                haddr = 32'h0;
  logic [1:0]                 htrans = 2'h0;
  logic                       hwrite = 1'b0;
  logic [2:0]                 hsize = 3'h0;
  logic [31:0]                hwdata = 32'h0;
  logic [31:0]                hrdata;
  logic                       hreadyout;
  logic                       hresp;
  logic                       link0 = 1'b0;
  logic                       link1 = 1'b0;
  logic                       traffic = 1'b0;
  logic [7:0]                 net_addr = 8'h00;
  logic [7:0]                 card_addr = 8'h00;
  fsl_pkg::fsl_rt_state_type  rt_state = '0;
  fsl_pkg::fsl_eip_state_type eip_state = '0;
  fsl_pkg::fsl_port_type      p0;
  fsl_pkg::fsl_port_type      p1;
  fsl_pkg::fsl_led_type       first;
  fsl_pkg::fsl_led_type       second;
  logic                       l0;
  logic                       l1;
  logic                       irq;
  logic [7:0]                 fb_addr;
  logic [31:0]                seed = 32'he3f755e0;
  logic [31:0]                r;
  logic [31:0]                res_v;
  logic [31:0]                q [$];
  event                       res_e;
  int                         mismatches = 0;
  int                         n_tests = 0;
  int                         cyc = 0;
  logic [27:0] rtt [5] = '{{12'h020, 4'h4, 6'h20, 6'h00}, {12'h002, 4'h4, 6'h08, 6'h00},
    {12'h120, 4'h0, 6'h20, 6'h20}, {12'h012, 4'h0, 6'h08, 6'h08}, {12'h000, 4'h0, 6'h00, 6'h00}};
  logic [27:0] eit [13] = '{{12'h000, 4'h0, 6'h00, 6'h00}, {12'he00, 4'h0, 6'h10, 6'h10},
    {12'hc80, 4'h0, 6'h20, 6'h20}, {12'hd00, 4'h4, 6'h10, 6'h00}, {12'hc40, 4'h4, 6'h20, 6'h00},
    {12'hc20, 4'h4, 6'h30, 6'h00}, {12'ha00, 4'h0, 6'h00, 6'h00}, {12'hc10, 4'h0, 6'h04, 6'h04},
    {12'hc08, 4'h4, 6'h04, 6'h00}, {12'hc06, 4'h0, 6'h08, 6'h08}, {12'hc02, 4'h4, 6'h08, 6'h00},
    {12'hc01, 4'h4, 6'h0c, 6'h00}, {12'h7ff, 4'h0, 6'h00, 6'h00}};
  always #2.5 hclk = ~hclk;
  fsl_leds #(.HALF_PERIOD_CYCLES(`FSL_DIV_W'(8))) i_dut
  (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .rt_state, .eip_state,
    .port_zero_channel(p0), .port_one_channel(p1), .net_addr, .card_addr,
    .first_port_connector(first), .second_port_connector(second),
    .port_zero_link_led(l0), .port_one_link_led(l1), .fieldbus_addr(fb_addr), .irq
  );
  fsl_partner i_ptr (.hclk, .link0, .link1, .traffic, .p0, .p1);
  task test_done;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  always @(res_e) cmp(res_v, q.pop_front());
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      mismatches++;
      $display("unexpected at %0t: timeout", $time);
      test_done;
    end
  end
  task note(input logic [31:0] e, input logic [31:0] g);
    q.push_back(e);
    res_v = g;
    -> res_e;
  endtask
  task ap(input logic [7:0] a, input logic w);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= 3'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    ap(a, 1'b1);
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    ap(a, 1'b0);
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    note(e, hrdata);
  endtask
  task pin(input logic e);
    repeat (5) @(posedge hclk);
    note({31'h0, e}, {31'h0, irq});
  endtask
  task win(input logic [3:0] n, input logic [5:0] o, input logic [5:0] a);
    logic [5:0] v;
    logic [5:0] pv;
    logic [5:0] vo;
    logic [5:0] va;
    logic [3:0] c;
    repeat (3) @(posedge hclk);
    pv = {first, second, l0, l1};
    vo = pv;
    va = pv;
    c = 4'h0;
    repeat (32)
    begin
      @(posedge hclk);
      v = {first, second, l0, l1};
      vo = vo | v;
      va = va & v;
      if (v[5:2] != pv[5:2]) c++;
      pv = v;
    end
    note({16'h0, n, o, a}, {16'h0, c, vo, va});
  endtask
  initial
  begin
    r = $random(seed);
    net_addr = r[7:0];
    card_addr = r[15:8];
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(8'h00, 32'h0);
    rd(8'h0c, 32'h0);
    rd(8'h08, 32'h0);
    wr(8'h10, 32'hffffffff);
    rd(8'h10, 32'h0);
    rd(8'h04, {16'h0, net_addr, 8'h00});
    @(posedge hclk);
    note({24'h0, net_addr}, {24'h0, fb_addr});
    wr(8'h00, 32'hffffffff);
    rd(8'h00, 32'h3);
    wr(8'h00, 32'h2);
    rd(8'h04, {16'h0, card_addr, 8'h00});
    @(posedge hclk);
    note({24'h0, card_addr}, {24'h0, fb_addr});
    wr(8'h00, 32'h0);
    $display("test registers done");
    foreach (rtt[i])
    begin
      rt_state <= rtt[i][24:16];
      win(rtt[i][15:12], rtt[i][11:6], rtt[i][5:0]);
    end
    repeat (8)
    begin
      r = $random(seed) & 32'h1dd;
      rt_state <= r[8:0];
      win(4'h0, {|r[8:6], 1'b0, |r[4:2], 3'h0}, {|r[8:6], 1'b0, |r[4:2], 3'h0});
      rd(8'h04, {16'h0, net_addr, 1'b0, r[0], 2'h0, |r[4:2], 1'b0, |r[8:6], 1'b0});
    end
    rt_state <= '0;
    link0 <= 1'b1;
    link1 <= 1'b1;
    traffic <= 1'b1;
    win(4'h0, 6'h03, 6'h00);
    $display("test real-time set done");
    link0 <= 1'b0;
    link1 <= 1'b0;
    traffic <= 1'b0;
    wr(8'h00, 32'h1);
    foreach (eit[i])
    begin
      eip_state <= eit[i][27:16];
      win(eit[i][15:12], eit[i][11:6], eit[i][5:0]);
    end
    link0 <= 1'b1;
    win(4'h0, 6'h02, 6'h02);
    $display("test network set done");
    wr(8'h08, 32'hf);
    wr(8'h0c, 32'h1);
    link0 <= 1'b0;
    pin(1'b1);
    rd(8'h08, 32'h1);
    wr(8'h0c, 32'h0);
    pin(1'b0);
    wr(8'h0c, 32'h4);
    eip_state <= 12'hc84;
    pin(1'b1);
    rd(8'h08, 32'hd);
    wr(8'h08, 32'h4);
    pin(1'b0);
    wr(8'h08, 32'h9);
    rd(8'h08, 32'h0);
    $display("test interrupt done");
    test_done;
  end
endmodule

//--- hw/fsl_cfg.svh
// Fieldbus status LED block: register map, field positions, reset values, timing.
// Assumes a 200 MHz system clock and word-aligned AHB-Lite register access.
`ifndef FSL_CFG_SVH
`define FSL_CFG_SVH

`define FSL_OFS_CTRL       8'h00
`define FSL_OFS_STATE      8'h04
`define FSL_OFS_IRQ_STAT   8'h08
`define FSL_OFS_IRQ_MASK   8'h0c

`define FSL_CTRL_VARIANT   0
`define FSL_CTRL_ADDR_SRC  1
`define FSL_CTRL_RST       2'h0
`define FSL_MASK_RST       4'h0

`define FSL_IRQ_LINK0      0
`define FSL_IRQ_LINK1      1
`define FSL_IRQ_FIRST_RED  2
`define FSL_IRQ_SECOND_RED 3

`define FSL_CLK_HZ         200000000
`define FSL_FLASH_HZ       2
`define FSL_HALF_CYCLES    (`FSL_CLK_HZ / (2 * `FSL_FLASH_HZ))
`define FSL_DIV_W          26

`endif

//--- hw/fsl_leds.sv
// Fieldbus status LED block: AHB-Lite register slave, flash divider, LED drive.
// Assumes status inputs come from logic on hclk; one AHB-Lite master, single word transfers.
`timescale 1ns/10ps
`include "fsl_cfg.svh"

module fsl_leds
#(
  parameter logic [`FSL_DIV_W-1:0] HALF_PERIOD_CYCLES = `FSL_DIV_W'(`FSL_HALF_CYCLES)
)
(
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic [31:0]                    hrdata,
  output logic                           hreadyout,
  output logic                           hresp,
  input  wire fsl_pkg::fsl_rt_state_type  rt_state,
  input  wire fsl_pkg::fsl_eip_state_type eip_state,
  input  wire fsl_pkg::fsl_port_type      port_zero_channel,
  input  wire fsl_pkg::fsl_port_type      port_one_channel,
  input  wire logic [7:0]                net_addr,
  input  wire logic [7:0]                card_addr,
  output fsl_pkg::fsl_led_type           first_port_connector,
  output fsl_pkg::fsl_led_type           second_port_connector,
  output logic                           port_zero_link_led,
  output logic                           port_one_link_led,
  output logic [7:0]                     fieldbus_addr,
  output logic                           irq
);

  logic [`FSL_DIV_W-1:0]    div_r;
  logic                     tick;
  logic                     blink_r;
  logic [1:0]               act_seen_r;
  logic [1:0]               ctrl_r;
  logic [3:0]               irq_stat_r;
  logic [3:0]               irq_mask_r;
  logic [3:0]               irq_set;
  logic                     wr_pend_r;
  logic [7:0]               wr_addr_r;
  logic                     addr_ok;
  logic [31:0]              rd_val;
  logic [1:0]               link_prev_r;
  fsl_pkg::fsl_led_type     first_r;
  fsl_pkg::fsl_led_type     second_r;
  fsl_pkg::fsl_led_type     first_nxt;
  fsl_pkg::fsl_led_type     second_nxt;
  fsl_pkg::fsl_variant_type variant;
  logic                     link0_r;
  logic                     link1_r;
  logic                     link0_nxt;
  logic                     link1_nxt;
  logic [7:0]               addr_r;
  logic                     irq_r;
  logic [31:0]              hrdata_r;

  assign variant = fsl_pkg::fsl_variant_type'(ctrl_r[`FSL_CTRL_VARIANT]);
  assign addr_ok = hsel & hready & htrans[1];

  assign tick = (div_r == HALF_PERIOD_CYCLES - `FSL_DIV_W'(1));

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div_r <= '0;
    end
    else if (tick)
    begin
      div_r <= '0;
    end
    else
    begin
      div_r <= div_r + `FSL_DIV_W'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      blink_r <= 1'b0;
    end
    else if (tick)
    begin
      blink_r <= ~blink_r;
    end
  end

  // Traffic seen in the current half period; a new frame wins over the clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      act_seen_r <= 2'h0;
    end
    else
    begin
      act_seen_r <= ({port_one_channel.activity, port_zero_channel.activity})
                    | (tick ? 2'h0 : act_seen_r);
    end
  end

  // Indicator decode
  always_comb
  begin
    first_nxt  = '0;
    second_nxt = '0;
    link0_nxt  = 1'b0;
    link1_nxt  = 1'b0;
    unique case (variant)
      fsl_pkg::FSL_VAR_RT:
      begin
        if (rt_state.no_config | rt_state.low_speed | rt_state.no_link)
        begin
          first_nxt.red = 1'b1;
        end
        else if (rt_state.no_data_exch)
        begin
          first_nxt.red = blink_r;
        end
        if (rt_state.wdog_timeout | rt_state.sys_error | rt_state.diag_pending)
        begin
          second_nxt.red = 1'b1;
        end
        else if (rt_state.dcp_signal)
        begin
          second_nxt.red = blink_r;
        end
        link0_nxt = port_zero_channel.link_up & ~(act_seen_r[0] & blink_r);
        link1_nxt = port_one_channel.link_up & ~(act_seen_r[1] & blink_r);
      end
      fsl_pkg::FSL_VAR_EIP:
      begin
        if (!eip_state.powered | !eip_state.ip_assigned)
        begin
          first_nxt = '0;
        end
        else if (eip_state.net_self_test)
        begin
          first_nxt.red   = blink_r;
          first_nxt.green = ~blink_r;
        end
        else if (eip_state.dup_ip)
        begin
          first_nxt.red = 1'b1;
        end
        else if (eip_state.conn_timeout)
        begin
          first_nxt.red = blink_r;
        end
        else if (eip_state.connected)
        begin
          first_nxt.green = 1'b1;
        end
        else if (eip_state.no_conn)
        begin
          first_nxt.green = blink_r;
        end
        if (!eip_state.powered)
        begin
          second_nxt = '0;
        end
        else if (eip_state.mod_self_test)
        begin
          second_nxt.red   = blink_r;
          second_nxt.green = ~blink_r;
        end
        else if (eip_state.major_fault)
        begin
          second_nxt.red = 1'b1;
        end
        else if (eip_state.minor_fault)
        begin
          second_nxt.red = blink_r;
        end
        else if (eip_state.operational)
        begin
          second_nxt.green = 1'b1;
        end
        else if (eip_state.standby)
        begin
          second_nxt.green = blink_r;
        end
        link0_nxt = port_zero_channel.link_up & ~(act_seen_r[0] & blink_r);
        link1_nxt = port_one_channel.link_up & ~(act_seen_r[1] & blink_r);
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      first_r  <= '0;
      second_r <= '0;
      link0_r  <= 1'b0;
      link1_r  <= 1'b0;
    end
    else
    begin
      first_r  <= first_nxt;
      second_r <= second_nxt;
      link0_r  <= link0_nxt;
      link1_r  <= link1_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_r <= 8'h00;
    end
    else
    begin
      addr_r <= ctrl_r[`FSL_CTRL_ADDR_SRC] ? card_addr : net_addr;
    end
  end

  // Bus write: address phase capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end
    else
    begin
      wr_pend_r <= addr_ok & hwrite;
      wr_addr_r <= haddr[7:0];
    end
  end

  // Control and mask registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_r     <= `FSL_CTRL_RST;
      irq_mask_r <= `FSL_MASK_RST;
    end
    else if (wr_pend_r)
    begin
      if (wr_addr_r == `FSL_OFS_CTRL)
      begin
        ctrl_r <= hwdata[1:0];
      end
      if (wr_addr_r == `FSL_OFS_IRQ_MASK)
      begin
        irq_mask_r <= hwdata[3:0];
      end
    end
  end

  // Interrupt events
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      link_prev_r <= 2'h0;
    end
    else
    begin
      link_prev_r <= {link1_nxt | port_one_channel.link_up,
                      link0_nxt | port_zero_channel.link_up};
    end
  end

  always_comb
  begin
    irq_set                      = 4'h0;
    irq_set[`FSL_IRQ_LINK0]      = port_zero_channel.link_up ^ link_prev_r[0];
    irq_set[`FSL_IRQ_LINK1]      = port_one_channel.link_up ^ link_prev_r[1];
    irq_set[`FSL_IRQ_FIRST_RED]  = first_nxt.red & ~first_r.red;
    irq_set[`FSL_IRQ_SECOND_RED] = second_nxt.red & ~second_r.red;
  end

  // Sticky status, write one to clear, set wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_stat_r <= 4'h0;
    end
    else if (wr_pend_r && (wr_addr_r == `FSL_OFS_IRQ_STAT))
    begin
      irq_stat_r <= (irq_stat_r & ~hwdata[3:0]) | irq_set;
    end
    else
    begin
      irq_stat_r <= irq_stat_r | irq_set;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_r <= 1'b0;
    end
    else
    begin
      irq_r <= |((irq_stat_r | irq_set) & irq_mask_r);
    end
  end

  // Read mux, unmapped reads as zero
  always_comb
  begin
    rd_val = 32'h0000_0000;
    unique case (haddr[7:0])
      `FSL_OFS_CTRL:     rd_val[1:0] = ctrl_r;
      `FSL_OFS_STATE:    rd_val = {16'h0000, addr_r, 1'b0, rt_state.irt_class,
                                   link1_r, link0_r, second_r, first_r};
      `FSL_OFS_IRQ_STAT: rd_val[3:0] = irq_stat_r;
      `FSL_OFS_IRQ_MASK: rd_val[3:0] = irq_mask_r;
      default:           rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata_r <= 32'h0000_0000;
    end
    else if (addr_ok && !hwrite)
    begin
      hrdata_r <= rd_val;
    end
  end

  assign hrdata                = hrdata_r;
  assign hreadyout             = 1'b1;
  assign hresp                 = 1'b0;
  assign first_port_connector  = first_r;
  assign second_port_connector = second_r;
  assign port_zero_link_led    = link0_r;
  assign port_one_link_led     = link1_r;
  assign fieldbus_addr         = addr_r;
  assign irq                   = irq_r;

endmodule

//--- hw/fsl_pkg.sv
// Fieldbus status LED block: shared types.
// Needs nothing from fsl_cfg.svh; every field is one bit wide.
package fsl_pkg;

  typedef enum logic
  {
    FSL_VAR_RT  = 1'b0,
    FSL_VAR_EIP = 1'b1
  } fsl_variant_type;

  typedef struct packed
  {
    logic no_config;
    logic low_speed;
    logic no_link;
    logic no_data_exch;
    logic wdog_timeout;
    logic sys_error;
    logic diag_pending;
    logic dcp_signal;
    logic irt_class;
  } fsl_rt_state_type;

  typedef struct packed
  {
    logic powered;
    logic ip_assigned;
    logic connected;
    logic no_conn;
    logic dup_ip;
    logic conn_timeout;
    logic net_self_test;
    logic operational;
    logic standby;
    logic major_fault;
    logic minor_fault;
    logic mod_self_test;
  } fsl_eip_state_type;

  typedef struct packed
  {
    logic link_up;
    logic activity;
  } fsl_port_type;

  typedef struct packed
  {
    logic red;
    logic green;
  } fsl_led_type;

endpackage
